/* File: logic/sts_consts.svh */
`ifndef STS_CONSTS_SVH
`define STS_CONSTS_SVH

// ==========================================================
// Clock rate
`define STS_CLK_HZ 200000000
`define STS_TICK_CYCLES (`STS_CLK_HZ / 1000)

// ==========================================================
// Startup milestones in milliseconds after the wake event, and the decision period of normal mode
`define STS_T_FIRST_AUX_REGULATOR_MS 20
`define STS_T_INIT_START_MS 23
`define STS_T_INIT_COMP_SLOW_MS 88
`define STS_T_INIT_COMP_FAST_MS 58
`define STS_T_FULL_SCAN_SLOW_MS 221
`define STS_T_FULL_SCAN_FAST_MS 129
`define STS_T_SWITCH_SLOW_MS 282
`define STS_T_SWITCH_FAST_MS 284
`define STS_T_DECIDE_MS 250

// ==========================================================
// Discharge drive pulsing window in microseconds
`define STS_T_PULSE_US 150
`define STS_PULSE_CYCLES ((`STS_T_PULSE_US * (`STS_CLK_HZ / 1000000)))

// ==========================================================
// Interrupt status bit positions
`define STS_IRQ_INIT_START 0
`define STS_IRQ_INIT_COMP 1
`define STS_IRQ_FULL_SCAN 2
`define STS_IRQ_SWITCH_ON 3
`define STS_IRQ_W 4

// ==========================================================
// Register offsets
`define STS_ADDR_STATUS 4'h0
`define STS_ADDR_MASK 4'h4

`endif

/* File: logic/sts_pkg.sv */
package sts_pkg;

    typedef enum logic [3:0] {
        STS_OFF = 4'h1,
        STS_WAKE = 4'h2,
        STS_NORMAL = 4'h4,
        STS_UNUSED = 4'h8
    } sts_state_t;

    typedef enum logic [2:0] {
        STS_DSG_IDLE = 3'h1,
        STS_DSG_PULSE = 3'h2,
        STS_DSG_HIZ = 3'h4
    } sts_dsg_t;

    typedef struct packed {
        logic init_started_flag;
        logic init_complete_flag;
        logic conversion_scan_flag;
        logic full_scan_flag;
    } sts_flags_t;

    typedef struct packed {
        logic charge_off_req;
        logic discharge_off_req;
        logic drive_below_load;
        logic drive_near_load;
    } sts_switch_in_t;

endpackage

/* File: logic/sts_seq.sv */
`include "sts_consts.svh"

module sts_seq
    import sts_pkg::*;
#(
    parameter int TICK_CYCLES = `STS_TICK_CYCLES,
    parameter int PULSE_CYCLES = `STS_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Wake and shutdown
    input wire logic second_thermistor_wake_pin_i,
    input wire logic load_sense_pin_i,
    input wire logic shutdown_req_i,
    // Configuration
    input wire logic fast_conversion_select_i,
    input wire logic autonomous_switch_control_i,
    input wire logic first_aux_regulator_auto_i,
    input wire sts_flags_t alert_select_i,
    input wire logic switch_enable_decision_i,
    // Switch driver control and comparators
    input wire sts_switch_in_t switch_i,
    // Interrupt register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    // Status outputs
    output logic normal_mode_o,
    output logic first_aux_regulator_en_o,
    output sts_flags_t flags_o,
    output logic alert_o,
    output logic switches_on_o,
    // Charge drive: high pulls toward stack top
    output logic charge_switch_drive_pull_o,
    // Discharge drive: pull-down output and enable (enable low while driving)
    output logic discharge_switch_drive_pull_o,
    output logic discharge_switch_drive_oe_n_o
);

    localparam logic [3:0] ADDR_STATUS = `STS_ADDR_STATUS;
    localparam logic [3:0] ADDR_MASK = `STS_ADDR_MASK;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] ms_pick(input logic fast, input int slow_ms, input int fast_ms);
        ms_pick = fast ? 16'(fast_ms) : 16'(slow_ms);
    endfunction

    sts_state_t state;
    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [15:0] decide_cnt;
    logic wake_evt;
    logic [`STS_IRQ_W-1:0] irq_status;
    logic [`STS_IRQ_W-1:0] irq_mask;
    logic [`STS_IRQ_W-1:0] irq_set;
    sts_dsg_t dsg_state;
    logic [31:0] pulse_cnt;
    logic switch_on_evt;

    assign wake_evt = (state == STS_OFF) && (!second_thermistor_wake_pin_i || load_sense_pin_i);
    assign ms_tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // ==========================================================
    // Milestone decode. Every milestone is judged on the tick that completes its
    // millisecond, so all of them share one comparison helper.
    function automatic logic ms_hit(input logic tick, input logic [15:0] cnt, input logic [15:0] target);
        ms_hit = tick && (cnt + 16'h0001 == target);
    endfunction

    logic hit_first_aux_regulator;
    logic hit_init_start;
    logic hit_init_comp;
    logic hit_full_scan;
    logic hit_switch;
    logic decide_due;

    assign hit_first_aux_regulator = ms_hit(ms_tick, ms_cnt, 16'(`STS_T_FIRST_AUX_REGULATOR_MS));
    assign hit_init_start = ms_hit(ms_tick, ms_cnt, 16'(`STS_T_INIT_START_MS));
    assign hit_init_comp = ms_hit(ms_tick, ms_cnt,
        ms_pick(fast_conversion_select_i, `STS_T_INIT_COMP_SLOW_MS, `STS_T_INIT_COMP_FAST_MS));
    assign hit_full_scan = ms_hit(ms_tick, ms_cnt,
        ms_pick(fast_conversion_select_i, `STS_T_FULL_SCAN_SLOW_MS, `STS_T_FULL_SCAN_FAST_MS));
    assign hit_switch = ms_hit(ms_tick, ms_cnt,
        ms_pick(fast_conversion_select_i, `STS_T_SWITCH_SLOW_MS, `STS_T_SWITCH_FAST_MS));
    // Periodic decision point, one tick in every decision period of normal mode.
    assign decide_due = (state == STS_NORMAL) && ms_tick && (decide_cnt == 16'(`STS_T_DECIDE_MS - 1));

    // ==========================================================
    // Power state
    // A shutdown request wins over a pending milestone, so the sequence can be cut at any point.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= STS_OFF;
        end else if (clk_en_i) begin
            case (state)
                STS_OFF: begin
                    if (wake_evt) begin
                        state <= STS_WAKE;
                    end
                end
                STS_WAKE: begin
                    if (shutdown_req_i) begin
                        state <= STS_OFF;
                    end else if (hit_full_scan) begin
                        state <= STS_NORMAL;
                    end
                end
                STS_NORMAL: begin
                    if (shutdown_req_i) begin
                        state <= STS_OFF;
                    end
                end
                default: begin
                    state <= STS_OFF;
                end
            endcase
        end
    end

    // ==========================================================
    // Millisecond timebase, held clear while off until the wake event.
    // The count saturates instead of wrapping, so a milestone can never fire a second time.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt <= 32'h0;
            ms_cnt <= 16'h0;
        end else if (clk_en_i) begin
            if (state == STS_OFF) begin
                tick_cnt <= 32'h0;
                ms_cnt <= 16'h0;
            end else if (ms_tick) begin
                tick_cnt <= 32'h0;
                if (ms_cnt != 16'hFFFF) begin
                    ms_cnt <= ms_cnt + 16'h0001;
                end
            end else begin
                tick_cnt <= tick_cnt + 32'h1;
            end
        end
    end

    // ==========================================================
    // Startup milestones. Each fires on the tick that completes its millisecond.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first_aux_regulator_en_o <= 1'b0;
            flags_o <= '0;
        end else if (clk_en_i) begin
            if (state == STS_OFF) begin
                first_aux_regulator_en_o <= 1'b0;
                flags_o <= '0;
            end else begin
                if (first_aux_regulator_auto_i && hit_first_aux_regulator) begin
                    first_aux_regulator_en_o <= 1'b1;
                end
                if (hit_init_start) begin
                    flags_o.init_started_flag <= 1'b1;
                end
                if (hit_init_comp) begin
                    flags_o.init_complete_flag <= 1'b1;
                    flags_o.conversion_scan_flag <= 1'b1;
                end
                if (hit_full_scan) begin
                    flags_o.full_scan_flag <= 1'b1;
                end
            end
        end
    end

    // Alert is active high here and shows the selected flags.
    // It lags the flags by one cycle because it is registered on its own.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            alert_o <= 1'b0;
        end else if (clk_en_i) begin
            alert_o <= |(flags_o & alert_select_i);
        end
    end

    // ==========================================================
    // Switch enable decision. The first evaluation is tied to the startup figure for
    // the selected speed; after that the decision waits for the periodic point, one whole period after
    // the entry into normal mode, even if data was ready, which keeps the switches from chattering on noisy measurements.
    assign switch_on_evt = autonomous_switch_control_i && switch_enable_decision_i && (decide_due || hit_switch);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            decide_cnt <= 16'h0;
        end else if (clk_en_i) begin
            if (state != STS_NORMAL) begin
                decide_cnt <= 16'h0;
            end else if (ms_tick) begin
                decide_cnt <= (decide_cnt == 16'(`STS_T_DECIDE_MS - 1)) ? 16'h0 : decide_cnt + 16'h0001;
            end
        end
    end

    // Once on, the switches only follow the decision at the periodic point, so a brief
    // dip in the measurement cannot open them between two decisions.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switches_on_o <= 1'b0;
        end else if (clk_en_i) begin
            if (state == STS_OFF || !autonomous_switch_control_i) begin
                switches_on_o <= 1'b0;
            end else if (switch_on_evt) begin
                switches_on_o <= 1'b1;
            end else if (decide_due) begin
                switches_on_o <= switch_enable_decision_i;
            end
        end
    end

    // ==========================================================
    // Charge drive turn-off: a plain switch toward the stack top.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            charge_switch_drive_pull_o <= 1'b0;
        end else if (clk_en_i) begin
            charge_switch_drive_pull_o <= switch_i.charge_off_req;
        end
    end

    // ==========================================================
    // Discharge drive turn-off. The comparator gates each pulse so the gate is
    // never pulled far below the load side, which would stress the switch.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dsg_state <= STS_DSG_IDLE;
            pulse_cnt <= 32'h0;
            discharge_switch_drive_pull_o <= 1'b0;
            discharge_switch_drive_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            case (dsg_state)
                STS_DSG_IDLE: begin
                    discharge_switch_drive_pull_o <= 1'b0;
                    discharge_switch_drive_oe_n_o <= 1'b1;
                    pulse_cnt <= 32'h0;
                    if (switch_i.discharge_off_req) begin
                        dsg_state <= STS_DSG_PULSE;
                    end
                end
                STS_DSG_PULSE: begin
                    pulse_cnt <= pulse_cnt + 32'h1;
                    discharge_switch_drive_pull_o <= 1'b0;
                    discharge_switch_drive_oe_n_o <= switch_i.drive_below_load;
                    if (pulse_cnt == 32'(PULSE_CYCLES - 1)) begin
                        dsg_state <= STS_DSG_HIZ;
                        discharge_switch_drive_oe_n_o <= 1'b1;
                    end
                end
                STS_DSG_HIZ: begin
                    discharge_switch_drive_pull_o <= 1'b0;
                    // Far from the load level the pulsing is retried rather than floating.
                    discharge_switch_drive_oe_n_o <= 1'b1;
                    if (!switch_i.discharge_off_req) begin
                        dsg_state <= STS_DSG_IDLE;
                    end else if (!switch_i.drive_near_load) begin
                        dsg_state <= STS_DSG_PULSE;
                        pulse_cnt <= 32'h0;
                    end
                end
                default: begin
                    dsg_state <= STS_DSG_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Interrupt status and mask. A new event wins over a clear in the same cycle.
    always_comb begin
        irq_set = '0;
        irq_set[`STS_IRQ_INIT_START] = hit_init_start;
        irq_set[`STS_IRQ_INIT_COMP] = hit_init_comp;
        irq_set[`STS_IRQ_FULL_SCAN] = hit_full_scan;
        irq_set[`STS_IRQ_SWITCH_ON] = switch_on_evt && !switches_on_o;
        // Nothing is recorded in shutdown, so a tick left from a cut sequence sets no bit.
        if (state == STS_OFF) begin
            irq_set = '0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else if (clk_en_i) begin
            if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
                irq_mask <= reg_wdata_i[`STS_IRQ_W-1:0];
            end
            if (reg_wr_i && reg_addr_i == ADDR_STATUS) begin
                irq_status <= (irq_status & ~reg_wdata_i[`STS_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
        end
    end

    // ==========================================================
    // Read port and interrupt line. Read data stand for one cycle and are zero
    // otherwise, so a late sample shows zero rather than a stale register.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
            reg_rdata_o <= 32'h0;
            normal_mode_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= |((irq_status | irq_set) & irq_mask);
            normal_mode_o <= (state == STS_NORMAL);
            if (reg_rd_i && reg_addr_i == ADDR_STATUS) begin
                reg_rdata_o <= {28'h0, irq_status};
            end else if (reg_rd_i && reg_addr_i == ADDR_MASK) begin
                reg_rdata_o <= {28'h0, irq_mask};
            end else begin
                reg_rdata_o <= 32'h0;
            end
        end
    end

endmodule // sts_seq

/* File: verification/sts_seq_sva.sv */
// ==========================================================
// Checker on the sequencer's ports
module sts_seq_sva
    import sts_pkg::*;
#(
    parameter int TICK_CYCLES = 10,
    parameter int PULSE_CYCLES = 12
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire sts_flags_t alert_select_i,
    input wire sts_switch_in_t switch_i,
    input wire logic normal_mode_o,
    input wire logic first_aux_regulator_en_o,
    input wire sts_flags_t flags_o,
    input wire logic alert_o,
    input wire logic charge_switch_drive_pull_o,
    input wire logic discharge_switch_drive_pull_o,
    input wire logic discharge_switch_drive_oe_n_o
);
    localparam int D_INIT = 3 * TICK_CYCLES;
    int low_run;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A pull that never lets go would drive the gate far below the load level.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_run <= 0;
        end else if (!discharge_switch_drive_oe_n_o) begin
            low_run <= low_run + 1;
        end else begin
            low_run <= 0;
        end
    end
    sequence first_aux_regulator_up;
        $rose(first_aux_regulator_en_o);
    endsequence
    sequence init_up;
        $rose(flags_o.init_started_flag);
    endsequence
    first_aux_regulator_to_init_a: assert property (first_aux_regulator_up |-> ##D_INIT init_up) else $error("init flag not 3 ms after regulator");
    alert_map_a: assert property (alert_o == |($past(flags_o) & $past(alert_select_i))) else $error("alert mismatch");
    charge_pull_a: assert property (!$past(sys_rst_i) |-> charge_switch_drive_pull_o == $past(switch_i.charge_off_req))
        else $error("charge pull mismatch");
    dsg_pull_a: assert property (!discharge_switch_drive_oe_n_o |-> !$past(switch_i.drive_below_load))
        else $error("pulling while below load");
    dsg_low_a: assert property (discharge_switch_drive_pull_o == 1'h0) else $error("pull-down level not low");
    pulse_window_a: assert property (low_run <= PULSE_CYCLES) else $error("pulse beyond window");
    flag_order_a: assert property (flags_o.full_scan_flag |-> flags_o.init_complete_flag && flags_o.init_started_flag)
        else $error("flags out of order");
    scan_pair_a: assert property (flags_o.init_complete_flag == flags_o.conversion_scan_flag)
        else $error("init complete and scan apart");
    normal_entry_a: assert property ($rose(flags_o.full_scan_flag) |=> $rose(normal_mode_o))
        else $error("normal mode not after full scan");
endmodule // sts_seq_sva

bind sts_seq sts_seq_sva #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_sva (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .alert_select_i(alert_select_i), .switch_i(switch_i),
    .normal_mode_o(normal_mode_o), .first_aux_regulator_en_o(first_aux_regulator_en_o), .flags_o(flags_o),
    .alert_o(alert_o), .charge_switch_drive_pull_o(charge_switch_drive_pull_o),
    .discharge_switch_drive_pull_o(discharge_switch_drive_pull_o),
    .discharge_switch_drive_oe_n_o(discharge_switch_drive_oe_n_o));

/* File: verification/sts_fet_model.sv */
// ==========================================================
// Gate of the discharge switch against the load level (0)
module sts_fet_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic oe_n_i,
    output logic below_o,
    output logic near_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int level = 0;
    // The gate relaxes upward when released, so pulsing must resume.
    always @(posedge clk_i) begin
        if (start_i) begin
            level <= 6;
        end else if (!oe_n_i) begin
            level <= level - 4;
        end else if (level < 2) begin
            level <= level + 4;
        end
    end
    assign below_o = level < 0;
    assign near_o = level < 6;
endmodule // sts_fet_model

/* File: verification/tb_top.sv */
// ==========================================================
// Bench
module tb_top;
    import sts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    logic clk_i = 0, sys_rst_i = 1, wake_n = 1, load = 0, shut = 0, fast = 0, dec = 1;
    logic chg_req = 0, dsg_req = 0, start = 0, wr = 0, rd = 0;
    logic cen = 1, auto_sw = 1, first_aux_regulator_en = 1;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic irq, normal, first_aux_regulator, alert, sw_on, chg_pull, dsg_pull, oe_n, below, near;
    sts_flags_t flags;
    sts_flags_t asel = 4'h8;
    sts_switch_in_t sw;
    int n_errors = 0;
    int tests_run = 0;
    assign sw = '{chg_req, dsg_req, below, near};
    always #2.5 clk_i = ~clk_i;
    sts_seq #(.TICK_CYCLES(T), .PULSE_CYCLES(12)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(cen),
        .second_thermistor_wake_pin_i(wake_n), .load_sense_pin_i(load), .shutdown_req_i(shut),
        .fast_conversion_select_i(fast), .autonomous_switch_control_i(auto_sw), .first_aux_regulator_auto_i(first_aux_regulator_en),
        .alert_select_i(asel), .switch_enable_decision_i(dec), .switch_i(sw), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
        .normal_mode_o(normal), .first_aux_regulator_en_o(first_aux_regulator), .flags_o(flags), .alert_o(alert),
        .switches_on_o(sw_on), .charge_switch_drive_pull_o(chg_pull), .discharge_switch_drive_pull_o(dsg_pull),
        .discharge_switch_drive_oe_n_o(oe_n));
    sts_fet_model fet (.clk_i(clk_i), .start_i(start), .oe_n_i(oe_n), .below_o(below), .near_o(near));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_i);
        wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_i);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic test_switch();
        int falls;
        logic prev;
        falls = 0;
        prev = 1'h1;
        @(posedge clk_i);
        chg_req <= 1'h1;
        dsg_req <= 1'h1;
        start <= 1'h1;
        @(posedge clk_i);
        start <= 1'h0;
        #1 check("charge pull", 1, chg_pull);
        repeat (40) begin
            @(posedge clk_i);
            #1 if (prev && !oe_n) falls++;
            prev = oe_n;
        end
        check("pulse count", 1, falls >= 2);
        check("hiz after window", 1, oe_n);
        @(posedge clk_i);
        chg_req <= 1'h0;
        dsg_req <= 1'h0;
        repeat (2) @(posedge clk_i);
        #1 check("charge released", 0, chg_pull);
        $display("test switch done");
    endtask
    task automatic test_startup(input logic f);
        int t;
        int e[8];
        int tm[8];
        logic [7:0] v;
        logic [31:0] d;
        reg_wr(4'h4, 32'h1);
        @(posedge clk_i);
        fast <= f;
        if (f) load <= 1'h1;
        else wake_n <= 1'h0;
        @(posedge clk_i);
        t = 0;
        tm = '{default: 0};
        e = '{20 * T, 23 * T, (f ? 58 : 88) * T, (f ? 129 : 221) * T, (f ? 129 : 221) * T + 1,
            23 * T + 1, 23 * T, (f ? 284 : 282) * T};
        while (sw_on !== 1'h1 && t < 300 * T) begin
            @(posedge clk_i);
            t++;
            #1 v = {first_aux_regulator, flags.init_started_flag, flags.init_complete_flag, flags.full_scan_flag,
                normal, alert, irq, sw_on};
            for (int i = 0; i < 8; i++) if (v[7 - i] === 1'h1 && tm[i] == 0) tm[i] = t;
        end
        for (int i = 0; i < 8; i++) check($sformatf("milestone %0d", i), e[i], tm[i]);
        @(posedge clk_i);
        dec <= 1'h0;
        t++;
        while (t < 300 * T) begin
            @(posedge clk_i);
            t++;
        end
        #1 check("switch held", 1, sw_on);
        while (sw_on === 1'h1 && t < e[4] + 250 * T + 3) begin
            @(posedge clk_i);
            t++;
            #1;
        end
        check("switch dropped", 0, sw_on);
        check("drop time", e[4] - 1 + 250 * T, t);
        reg_rd(4'h0, d);
        check("status", 32'hF, d);
        check("flags all", 32'hF, flags);
        reg_wr(4'h0, 32'h1);
        reg_rd(4'h0, d);
        check("status cleared", 32'hE, d);
        check("irq cleared", 0, irq);
        reg_rd(4'h4, d);
        check("mask", 32'h1, d);
        reg_rd(4'h8, d);
        check("unmapped", 32'h0, d);
        @(posedge clk_i);
        shut <= 1'h1;
        wake_n <= 1'h1;
        load <= 1'h0;
        dec <= 1'h1;
        repeat (3) @(posedge clk_i);
        #1 check("flags off", 0, flags);
        check("normal off", 0, normal);
        @(posedge clk_i);
        shut <= 1'h0;
        $display("test startup fast=%0d done", f);
    endtask
    task automatic test_config();
        int t;
        @(posedge clk_i);
        auto_sw <= 1'h0;
        first_aux_regulator_en <= 1'h0;
        wake_n <= 1'h0;
        @(posedge clk_i);
        cen <= 1'h0;
        t = 0;
        repeat (10) begin
            @(posedge clk_i);
            t++;
        end
        cen <= 1'h1;
        while (flags.init_started_flag !== 1'h1 && t < 30 * T) begin
            @(posedge clk_i);
            t++;
            #1;
        end
        check("frozen init start", 23 * T + 10, t);
        while (t < 285 * T + 10) begin
            @(posedge clk_i);
            t++;
        end
        #1 check("regulator off", 0, first_aux_regulator);
        check("switch manual", 0, sw_on);
        check("normal reached", 1, normal);
        @(posedge clk_i);
        shut <= 1'h1;
        wake_n <= 1'h1;
        auto_sw <= 1'h1;
        first_aux_regulator_en <= 1'h1;
        repeat (3) @(posedge clk_i);
        @(posedge clk_i);
        shut <= 1'h0;
        $display("test config done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        test_switch();
        test_startup(1'h0);
        test_startup(1'h1);
        test_config();
        complete_run();
    end
    // All scenarios together take about twelve thousand cycles.
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule // tb_top
